// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import tep_pkg::*;
   logic i_clock = 1'b0, i_rst = 1'b1, sel = 1'b0, rx_en = 1'b1, go = 1'b0, rd_seen = 1'b0;
   logic frame_sync_event, strobe, cv, sl, busy, end_of_message;
   tep_req_t req = '0;
   logic [7:0] tx_bits = 8'h00, tx_lvl = 8'h00, fsk = 8'h00, level, o_rdata, b, pk2 = 8'h00;
   logic [7:0] ofs = 8'h00, pk1 = 8'h00;
   logic [5:0] ask = 6'h00;
   logic [1:0] tx_fault = 2'h0;
   logic [15:0] pat_a, pat_b, pa [2], pb [2], rdq [$];
   // Set, control, limit, fault, end bit count
   logic [31:0] tbl [9] = '{32'h0100_0001, 32'h01FF_0100, 32'h0105_0006, 32'h0209_1002,
      32'h0409_2002, 32'h0104_1005, 32'h0700_1001, 32'h0609_2002, 32'h1209_1002};
   int eomq [$];
   int nbits = 0, fail_count = 0, samples_checked = 0;
   tep_core dut_u (.i_clock, .i_rst, .i_req(req), .i_set_b_sel(sel), .i_rx_enable(rx_en),
      .i_bit_strobe(strobe), .i_frame_sync_event(frame_sync_event), .i_sync_lost(sl), .i_code_violation(cv),
      .i_level(level), .i_fsk_noise(fsk), .i_ask_noise(ask), .i_peak_start_offset(ofs),
      .o_rdata, .o_end_of_message(end_of_message), .o_in_message(), .o_pattern_a(pat_a), .o_pattern_b(pat_b));
   tep_tx_model tx_u (.i_clock, .i_go(go), .i_bits(tx_bits), .i_lvl(tx_lvl), .i_fault(tx_fault),
      .o_frame_sync_event(frame_sync_event), .o_strobe(strobe), .o_cv(cv), .o_sl(sl), .o_busy(busy), .o_level(level));
   initial begin
      forever #2 i_clock = ~i_clock;
   end
   task automatic complete_run();
      $display("Checked %0d, failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: value %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_cnt(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         fail_count++;
         $display("Error %0t: end after %0d bits, expected %0d", $time, got, exp);
      end
   endtask : cmp_cnt
   // Register access; for a read, d is the expected answer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int n);
      if (!w) repeat (n) rdq.push_back({8'h00, d});
      @(negedge i_clock);
      req = '{w, !w, a, w ? d : 8'h00};
      repeat (n) @(negedge i_clock);
      req = '0;
   endtask : xfer
   // A negative end count means no end is expected; pk1 holds the expected peak
   task automatic run_frame(input int e);
      if (e >= 0) eomq.push_back(e);
      @(negedge i_clock) go = 1'b1;
      @(negedge i_clock) go = 1'b0;
      @(negedge i_clock);
      repeat (2000) if (busy !== 1'b0) @(negedge i_clock);
      if (busy !== 1'b0) begin
         fail_count++;
         $display("Error %0t: frame did not finish", $time);
      end
      xfer(0, ADDR_PAYLOAD_PEAK, pk1, 1);
   endtask : run_frame
   // Answers land one cycle after the read; ends are timed in bits
   always @(posedge i_clock) begin
      rd_seen <= req.rd;
      nbits <= frame_sync_event ? 0 : nbits + int'(strobe);
   end
   always @(negedge i_clock) begin
      if (rd_seen) cmp_val({8'h00, o_rdata}, rdq.size() ? rdq.pop_front() : 'x);
      if (end_of_message === 1'b1) cmp_cnt(nbits, eomq.size() ? eomq.pop_front() : -1);
   end
   initial begin
      void'($urandom(32'h80af));
      repeat (20) @(negedge i_clock);
      i_rst = 1'b0;
      xfer(0, ADDR_PAYLOAD_PEAK, 8'h00, 1);
      xfer(0, ADDR_RUNNING_PEAK, 8'h00, 1);
      for (int s = 0; s < 2; s++) begin
         {pa[s], pb[s]} = $urandom;
         b = s ? ADDR_PAT_A_LOW_B : ADDR_PAT_A_LOW_A;
         for (int k = 0; k < 4; k++) xfer(1, b + 8'(k), 8'({pb[s], pa[s]} >> (8 * k)), 1);
      end
      for (int s = 0; s < 2; s++) begin
         sel = s[0];
         repeat (3) @(negedge i_clock);
         cmp_val(pat_a, pa[s]);
         cmp_val(pat_b, pb[s]);
      end
      foreach (tbl[i]) begin
         sel = tbl[i][28];
         b = sel ? ADDR_EOM_CTRL_B : ADDR_EOM_CTRL_A;
         xfer(1, b, {5'h00, tbl[i][26:24]}, 1);
         xfer(1, b + 8'h01, tbl[i][23:16], 1);
         {tx_bits, tx_fault, tx_lvl} = {tbl[i][23:16] | 8'h02, tbl[i][13:12], 8'($urandom)};
         ofs = 8'($urandom % 4);
         pk1 = int'(tbl[i][11:0]) > int'(ofs) ? tx_lvl : 8'h00;
         pk2 = tx_lvl > pk2 ? tx_lvl : pk2;
         run_frame(int'(tbl[i][11:0]));
         if (i[0]) begin
            xfer(0, ADDR_RUNNING_PEAK, pk2, 1);
            pk2 = 8'h00;
         end
      end
      xfer(0, ADDR_RUNNING_PEAK, pk2, 1);
      rx_en = 1'b0;
      tx_lvl = 8'hF0;
      run_frame(-1);
      xfer(0, ADDR_RUNNING_PEAK, 8'h00, 2);
      for (int a = 0; a < 6; a++) begin
         xfer(0, ADDR_PAT_A_LOW_A + 8'(a), READ_ZERO, 1);
         xfer(0, ADDR_PAT_A_LOW_B + 8'(a), READ_ZERO, 1);
      end
      xfer(0, 8'hAE, READ_ZERO, 1);
      {fsk, ask} = 14'($urandom);
      xfer(1, ADDR_FSK_NOISE, 8'hFF, 1);
      xfer(0, ADDR_FSK_NOISE, fsk, 1);
      xfer(0, ADDR_ASK_NOISE, {2'h0, ask}, 1);
      repeat (5) @(negedge i_clock);
      cmp_cnt(eomq.size(), 0);
      complete_run();
   end
   // Hang guard, well past the expected run of under two thousand cycles
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end
endmodule : tb_top
bind tep_core tep_props u_props (.i_clock, .i_rst, .i_req, .i_set_b_sel, .i_rx_enable,
   .i_bit_strobe, .i_sync_lost, .i_code_violation, .i_fsk_noise, .i_ask_noise, .o_rdata,
   .o_end_of_message, .o_in_message);
`default_nettype wire

// File: tep_core.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE_01 - The high pattern A byte of a set supplies chips 15 to 8, top chip in bit 7.
// RULE_02 - Pattern B is built from its written low and high bytes, in chips.
// RULE_03 - With end control bit 2 set, loss of symbol sync ends the message.
// RULE_04 - With end control bit 1 set, a line code violation ends the message.
// RULE_05 - With end control bit 0 set, reaching the data field length ends the message.
// RULE_06 - Enabled end criteria combine, and the first one to occur ends the message.
// RULE_07 - Software writes zero to the unused end control bit 3.
// RULE_08 - Length counting starts after the last sync word bit; 00h ends on the next bit.
// RULE_09 - The FSK noise power reads back as an 8-bit read-only value.
// RULE_10 - The ASK noise power reads back as a 6-bit value in the low bits.
// RULE_11 - Peak detector 1 tracks from frame sync plus offset and latches at message end.
// RULE_12 - Peak detector 2 tracks while the digital receiver is enabled.
// RULE_13 - Peak detector 2 only replaces its value with a higher level.
// RULE_14 - Peak detector 2 clears at reset and when read by the host. A read in a cycle that brings a higher level keeps that level instead.
// RULE_15 - The low pattern A byte supplies chips 7 to 0, bottom chip in bit 0.
// RULE_16 - Sync patterns are at most 16 chips long.
module tep_core #(
   parameter int OFFSET_W = 8
) (
   input  wire  logic                   i_clock,
   input  wire  logic                   i_rst,
   input  wire  tep_pkg::tep_req_t      i_req,
   input  wire  logic                   i_set_b_sel,
   input  wire  logic                   i_rx_enable,
   input  wire  logic                   i_bit_strobe,
   input  wire  logic                   i_frame_sync_event,
   input  wire  logic                   i_sync_lost,
   input  wire  logic                   i_code_violation,
   input  wire  logic [7:0]             i_level,
   input  wire  logic [7:0]             i_fsk_noise,
   input  wire  logic [5:0]             i_ask_noise,
   input  wire  logic [OFFSET_W-1:0]    i_peak_start_offset,
   output var   logic [7:0]             o_rdata,
   output var   logic                   o_end_of_message,
   output var   logic                   o_in_message,
   output var   logic [15:0]            o_pattern_a,
   output var   logic [15:0]            o_pattern_b
);
   import tep_pkg::*;

   tep_cfg_t      cfg_a_r;
   tep_cfg_t      cfg_b_r;
   tep_cfg_t      cfg_sel;
   tep_state_t    state_r;
   logic [7:0]    len_cnt_r;
   logic [OFFSET_W-1:0] ofs_cnt_r;
   logic          tracking_r;
   logic [7:0]    track_peak_r;
   logic [7:0]    payload_peak_r;
   logic [7:0]    running_peak_r;
   logic [7:0]    fsk_noise_r;
   logic [5:0]    ask_noise_r;
   logic          end_now;
   logic          len_hit;

   // Active set for the framer
   assign cfg_sel = i_set_b_sel ? cfg_b_r : cfg_a_r;

   // Register writes; patterns are full 16 chips (see RULE_16)
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cfg_a_r <= '0;
         cfg_b_r <= '0;
      end else if (i_req.wr) begin
         unique case (i_req.addr)
            ADDR_PAT_A_LOW_A:  cfg_a_r.pattern_a[7:0]  <= i_req.wdata;  // see RULE_15
            ADDR_PAT_A_HIGH_A: cfg_a_r.pattern_a[15:8] <= i_req.wdata;  // see RULE_01
            ADDR_PAT_B_LOW_A:  cfg_a_r.pattern_b[7:0]  <= i_req.wdata;  // see RULE_02
            ADDR_PAT_B_HIGH_A: cfg_a_r.pattern_b[15:8] <= i_req.wdata;  // see RULE_02
            // Bit 3 is expected zero and is not stored (see RULE_07)
            ADDR_EOM_CTRL_A:   cfg_a_r.end_ctrl        <= i_req.wdata[EOM_BIT_SYNC_LOSS:0];
            ADDR_LEN_LIMIT_A:  cfg_a_r.length_limit    <= i_req.wdata;
            ADDR_PAT_A_LOW_B:  cfg_b_r.pattern_a[7:0]  <= i_req.wdata;  // see RULE_15
            ADDR_PAT_A_HIGH_B: cfg_b_r.pattern_a[15:8] <= i_req.wdata;  // see RULE_01
            ADDR_PAT_B_LOW_B:  cfg_b_r.pattern_b[7:0]  <= i_req.wdata;  // see RULE_02
            ADDR_PAT_B_HIGH_B: cfg_b_r.pattern_b[15:8] <= i_req.wdata;  // see RULE_02
            ADDR_EOM_CTRL_B:   cfg_b_r.end_ctrl        <= i_req.wdata[EOM_BIT_SYNC_LOSS:0];
            ADDR_LEN_LIMIT_B:  cfg_b_r.length_limit    <= i_req.wdata;
            default: ;
         endcase
      end
   end

   // Patterns to the correlator, registered
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pattern_a <= '0;
         o_pattern_b <= '0;
      end else begin
         o_pattern_a <= cfg_sel.pattern_a;  // see RULE_01
         o_pattern_b <= cfg_sel.pattern_b;  // see RULE_02
      end
   end

   // Length reached when the counted bits equal the limit (see RULE_08)
   assign len_hit = i_bit_strobe && (len_cnt_r == cfg_sel.length_limit);

   // Any enabled criterion ends the message; first one wins (see RULE_06)
   assign end_now = (state_r == ST_PAYLOAD) && (
        (cfg_sel.end_ctrl[EOM_BIT_SYNC_LOSS] && i_sync_lost)        // see RULE_03
     || (cfg_sel.end_ctrl[EOM_BIT_VIOLATION] && i_code_violation)   // see RULE_04
     || (cfg_sel.end_ctrl[EOM_BIT_LENGTH] && len_hit));             // see RULE_05

   // Message state; frame sync starts the data field
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
      end else if (!i_rx_enable) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE:    if (i_frame_sync_event) state_r <= ST_PAYLOAD;
            ST_SYNC:    state_r <= ST_PAYLOAD;
            ST_PAYLOAD: if (end_now) state_r <= ST_IDLE;
         endcase
      end
   end

   // Bit counter from the bit after the sync word (see RULE_08)
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         len_cnt_r <= REG_RESET;
      end else if (state_r != ST_PAYLOAD) begin
         len_cnt_r <= REG_RESET;
      end else if (i_bit_strobe && len_cnt_r != LEN_SATURATE) begin
         len_cnt_r <= len_cnt_r + LEN_STEP;  // Saturates, so a FFh limit still hits
      end
   end

   // End pulse and in-message level
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_end_of_message <= 1'b0;
         o_in_message     <= 1'b0;
      end else begin
         o_end_of_message <= end_now;
         o_in_message     <= (state_r == ST_PAYLOAD) && !end_now;
      end
   end

   // Peak detector 1: offset wait, track, latch at end (see RULE_11)
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ofs_cnt_r      <= '0;
         tracking_r     <= 1'b0;
         track_peak_r   <= REG_RESET;
         payload_peak_r <= REG_RESET;
      end else if (end_now) begin
         payload_peak_r <= (tracking_r && i_level > track_peak_r) ? i_level : track_peak_r;
         tracking_r     <= 1'b0;
      end else if (state_r == ST_IDLE && i_frame_sync_event && i_rx_enable) begin
         ofs_cnt_r    <= i_peak_start_offset;
         tracking_r   <= (i_peak_start_offset == '0);
         track_peak_r <= REG_RESET;
      end else if (state_r == ST_PAYLOAD) begin
         if (!tracking_r) begin
            // Offset counted in received bits
            if (ofs_cnt_r == '0) tracking_r <= 1'b1;
            else if (i_bit_strobe) ofs_cnt_r <= ofs_cnt_r - 1'b1;
         end else if (i_level > track_peak_r) begin
            track_peak_r <= i_level;
         end
      end else begin
         tracking_r <= 1'b0;
      end
   end

   // Peak detector 2; a read clears, but a new peak that cycle wins
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         running_peak_r <= REG_RESET;                                        // see RULE_14
      end else if (i_rx_enable && i_level > running_peak_r) begin            // see RULE_12
         running_peak_r <= i_level;                                          // see RULE_13
      end else if (i_req.rd && i_req.addr == ADDR_RUNNING_PEAK) begin
         running_peak_r <= REG_RESET;                                        // see RULE_14
      end
   end

   // Noise readings sampled each cycle; sources are on this clock
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fsk_noise_r <= REG_RESET;
         ask_noise_r <= '0;
      end else begin
         fsk_noise_r <= i_fsk_noise;  // see RULE_09
         ask_noise_r <= i_ask_noise;  // see RULE_10
      end
   end

   // Read data registered; write-only and unmapped read zero
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= READ_ZERO;
      end else if (i_req.rd) begin
         unique case (i_req.addr)
            ADDR_PAYLOAD_PEAK: o_rdata <= payload_peak_r;
            ADDR_RUNNING_PEAK: o_rdata <= running_peak_r;
            ADDR_FSK_NOISE:    o_rdata <= fsk_noise_r;                  // see RULE_09
            ADDR_ASK_NOISE:    o_rdata <= 8'(ask_noise_r);              // see RULE_10
            default:           o_rdata <= READ_ZERO;
         endcase
      end
   end

endmodule : tep_core

`default_nettype wire

// File: tep_pkg.sv
package tep_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_PAT_A_LOW_A   = 8'h86;
   localparam logic [7:0] ADDR_PAT_A_HIGH_A  = 8'h87;
   localparam logic [7:0] ADDR_PAT_B_LOW_A   = 8'h88;
   localparam logic [7:0] ADDR_PAT_B_HIGH_A  = 8'h89;
   localparam logic [7:0] ADDR_EOM_CTRL_A    = 8'h8A;
   localparam logic [7:0] ADDR_LEN_LIMIT_A   = 8'h8B;
   localparam logic [7:0] ADDR_PAT_A_LOW_B   = 8'hA6;
   localparam logic [7:0] ADDR_PAT_A_HIGH_B  = 8'hA7;
   localparam logic [7:0] ADDR_PAT_B_LOW_B   = 8'hA8;
   localparam logic [7:0] ADDR_PAT_B_HIGH_B  = 8'hA9;
   localparam logic [7:0] ADDR_EOM_CTRL_B    = 8'hAA;
   localparam logic [7:0] ADDR_LEN_LIMIT_B   = 8'hAB;
   localparam logic [7:0] ADDR_PAYLOAD_PEAK  = 8'hAC;
   localparam logic [7:0] ADDR_RUNNING_PEAK  = 8'hAD;
   localparam logic [7:0] ADDR_FSK_NOISE     = 8'hAF;
   localparam logic [7:0] ADDR_ASK_NOISE     = 8'hB0;

   // Control field positions and field widths
   localparam int EOM_BIT_LENGTH    = 0;
   localparam int EOM_BIT_VIOLATION = 1;
   localparam int EOM_BIT_SYNC_LOSS = 2;
   localparam int ASK_NOISE_W       = 6;
   localparam int PATTERN_CHIPS     = 16;

   // Data length counter step and its ceiling
   localparam logic [7:0] LEN_SATURATE = 8'hFF;
   localparam logic [7:0] LEN_STEP     = 8'h01;

   // Reset values
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [7:0] READ_ZERO  = 8'h00;

   // One configuration set
   typedef struct packed {
      logic [15:0] pattern_a;
      logic [15:0] pattern_b;
      logic [2:0]  end_ctrl;
      logic [7:0]  length_limit;
   } tep_cfg_t;

   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tep_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SYNC,
      ST_PAYLOAD
   } tep_state_t;

endpackage : tep_pkg

// File: tep_props.sv
`timescale 1ns/10ps
`default_nettype none
module tep_props (
   input wire logic              i_clock,
   input wire logic              i_rst,
   input wire tep_pkg::tep_req_t i_req,
   input wire logic              i_set_b_sel,
   input wire logic              i_rx_enable,
   input wire logic              i_bit_strobe,
   input wire logic              i_sync_lost,
   input wire logic              i_code_violation,
   input wire logic [7:0]        i_fsk_noise,
   input wire logic [5:0]        i_ask_noise,
   input wire logic [7:0]        o_rdata,
   input wire logic              o_end_of_message,
   input wire logic              o_in_message
);
   import tep_pkg::*;
   logic [2:0] ctl_r [2];
   logic [7:0] lim_r [2];
   // Shadow of the end settings, which cannot be read back
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctl_r <= '{3'h0, 3'h0};
         lim_r <= '{8'h00, 8'h00};
      end else if (i_req.wr) begin
         if (i_req.addr == ADDR_EOM_CTRL_A) ctl_r[0] <= i_req.wdata[2:0];
         if (i_req.addr == ADDR_EOM_CTRL_B) ctl_r[1] <= i_req.wdata[2:0];
         if (i_req.addr == ADDR_LEN_LIMIT_A) lim_r[0] <= i_req.wdata;
         if (i_req.addr == ADDR_LEN_LIMIT_B) lim_r[1] <= i_req.wdata;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Peak read while tracking is off
   sequence s_peak_rd;
      i_req.rd && i_req.addr == ADDR_RUNNING_PEAK && !i_rx_enable;
   endsequence
   a_end_one_cycle: assert property (o_end_of_message |=> !o_end_of_message)
      else $error("end pulse too long");
   a_end_in_msg: assert property (o_end_of_message |-> $past(o_in_message))
      else $error("end outside a message");
   a_viol_ends: assert property (o_in_message && i_code_violation && ctl_r[i_set_b_sel][1]
      |=> o_end_of_message) else $error("violation did not end");
   a_loss_ends: assert property (o_in_message && i_sync_lost && ctl_r[i_set_b_sel][2]
      |=> o_end_of_message) else $error("sync loss did not end");
   a_len_zero_end: assert property (o_in_message && i_bit_strobe && ctl_r[i_set_b_sel][0]
      && lim_r[i_set_b_sel] == 8'h00 |=> o_end_of_message) else $error("no end on bit");
   a_fsk_read: assert property (i_req.rd && i_req.addr == ADDR_FSK_NOISE
      |=> o_rdata == $past(i_fsk_noise, 2)) else $error("fsk noise read wrong");
   a_ask_read: assert property (i_req.rd && i_req.addr == ADDR_ASK_NOISE
      |=> o_rdata == {2'h0, $past(i_ask_noise, 2)}) else $error("ask noise read wrong");
   a_peak_cleared: assert property (s_peak_rd ##1 s_peak_rd |=> o_rdata == READ_ZERO)
      else $error("peak not cleared by read");
endmodule : tep_props
`default_nettype wire

// File: tep_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module tep_tx_model (
   input  wire logic       i_clock,
   input  wire logic       i_go,
   input  wire logic [7:0] i_bits,
   input  wire logic [7:0] i_lvl,
   input  wire logic [1:0] i_fault,
   output var  logic       o_frame_sync_event,
   output var  logic       o_strobe,
   output var  logic       o_cv,
   output var  logic       o_sl,
   output var  logic       o_busy,
   output var  logic [7:0] o_level
);
   // Sync mark, then i_bits+1 bits four cycles apart; fault on the second bit
   initial begin
      {o_frame_sync_event, o_strobe, o_cv, o_sl, o_busy, o_level} = '0;
      forever begin
         @(posedge i_clock);
         if (i_go) begin
            @(negedge i_clock);
            {o_frame_sync_event, o_busy, o_level} = {2'h3, i_lvl};
            @(negedge i_clock);
            o_frame_sync_event = 1'b0;
            for (int n = 0; n <= int'(i_bits); n++) begin
               repeat (3) @(negedge i_clock);
               {o_strobe, o_cv, o_sl} = {1'b1, i_fault == 2'h1 && n == 1, i_fault == 2'h2 && n == 1};
               @(negedge i_clock);
               {o_strobe, o_cv, o_sl} = 3'h0;
            end
            repeat (4) @(negedge i_clock);
            {o_busy, o_level} = 9'h000;
         end
      end
   end
endmodule : tep_tx_model
`default_nettype wire
